// ===== src/acet_consts.svh
// constants of the converter compare-event trigger block
`ifndef ACET_CONSTS_SVH
`define ACET_CONSTS_SVH
`define ACET_OFF_FLAGS_ONE     8'h00
`define ACET_OFF_ENABLES_ONE   8'h04
`define ACET_OFF_PRIORITY_ONE  8'h08
`define ACET_OFF_FLAGS_TWO     8'h0C
`define ACET_OFF_ENABLES_TWO   8'h10
`define ACET_OFF_PRIORITY_TWO  8'h14
`define ACET_OFF_RESULT_HIGH   8'h18
`define ACET_OFF_RESULT_LOW    8'h1C
`define ACET_OFF_CONTROL_ZERO  8'h20
`define ACET_OFF_CONTROL_ONE   8'h24
`define ACET_OFF_COMPARE_CTL   8'h28
`define ACET_OFF_IRQ_STATUS    8'h2C
`define ACET_OFF_IRQ_MASK      8'h30
`define ACET_RST_FLAGS_ONE     8'h00
`define ACET_RST_ENABLES_ONE   8'h00
`define ACET_RST_PRIORITY_ONE  8'h00
`define ACET_RST_FLAGS_TWO     8'h00
`define ACET_RST_ENABLES_TWO   8'h00
`define ACET_RST_PRIORITY_TWO  8'h1F
`define ACET_RST_CONTROL_ZERO  8'h00
`define ACET_RST_CONTROL_ONE   8'h00
`define ACET_RST_COMPARE_CTL   8'h00
`define ACET_RST_IRQ           8'h00
`define ACET_RST_RESULT        8'h00
`define ACET_MODE_SPECIAL_EVT  4'hB
`define ACET_BIT_CONV_FLAG     6
`define ACET_BIT_PORT_RSVD     7
`define ACET_BIT_CMP_TWO_FLAG  0
`define ACET_BIT_CONV_ON       0
`define ACET_BIT_GO            2
`define ACET_BIT_RIGHT_JUST    7
`define ACET_BIT_TIMER_THIRD   4
`define ACET_MASK_FLAGS_TWO    8'h1F
`define ACET_MASK_CONTROL_ZERO 8'hFD
`define ACET_MASK_CONTROL_ONE  8'hCF
`define ACET_MASK_COMPARE_CTL  8'h1F
`define ACET_MASK_PORT_RSVD    8'h7F
`define ACET_IRQ_SPECIAL_EVT   0
`define ACET_IRQ_CONV_DONE     1
`define ACET_IRQ_IGNORED       2
`define ACET_CONV_CYCLES       12
`endif

// ===== src/acet_pkg.sv
// types of the converter compare-event trigger block
`default_nettype none
package acet_pkg;
   typedef enum logic [0:0] {
      ACET_IDLE = 1'b0,
      ACET_CONV = 1'b1
   } acet_seq_state_t;
endpackage
`default_nettype wire

// ===== src/acet_wb_slave.sv
// classic wishbone handshake: one wait state, single-cycle ack
`default_nettype none
module acet_wb_slave (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_wb_cyc,
   input  wire logic i_wb_stb,
   output logic      o_acc,
   output logic      o_wb_ack
);
   logic ack_r;
   logic ack_nxt;

   // access accepted once; ack drops the cycle after it was given
   always_comb begin
      o_acc   = i_wb_cyc & i_wb_stb & ~ack_r;
      ack_nxt = o_acc;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else if (i_ce) begin
         ack_r <= ack_nxt;
      end
   end

   assign o_wb_ack = ack_r;

   a_ack_single: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (ack_r && i_ce) |=> !ack_r) else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ===== src/acet_conv_seq.sv
// conversion sequencer: times a conversion while go stays set
`default_nettype none
`include "acet_consts.svh"
module acet_conv_seq #(
   parameter int CONV_CYCLES = `ACET_CONV_CYCLES
) (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   input  wire logic i_go,
   output logic      o_busy,
   output logic      o_done
);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);

   acet_pkg::acet_seq_state_t state_r;
   acet_pkg::acet_seq_state_t state_nxt;
   logic [CW-1:0]             cnt_r;
   logic [CW-1:0]             cnt_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      o_done    = 1'b0;
      case (state_r)
         acet_pkg::ACET_IDLE: begin
            cnt_nxt = '0;
            if (i_go) begin
               state_nxt = acet_pkg::ACET_CONV;
            end
         end
         acet_pkg::ACET_CONV: begin
            // clearing go by software aborts without a result
            if (!i_go) begin
               state_nxt = acet_pkg::ACET_IDLE;
            end else if (cnt_r == LAST) begin
               o_done    = 1'b1;
               state_nxt = acet_pkg::ACET_IDLE;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
         default: begin
            state_nxt = acet_pkg::ACET_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= acet_pkg::ACET_IDLE;
         cnt_r   <= '0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign o_busy = (state_r == acet_pkg::ACET_CONV);
endmodule
`default_nettype wire

// ===== src/acet_top.sv
// converter control with compare special-event trigger and timer clear
//
// Contract
// - trigger starts conversion only with compare mode 1011 and converter on
// - trigger sets go bit, starting conversion like a software write
// - every special event in compare mode 1011 while i_ce is high clears the counter of the serving timer
// - converter off: event starts nothing but still clears the timer
`default_nettype none
`include "acet_consts.svh"
module acet_top #(
   parameter int CONV_CYCLES = `ACET_CONV_CYCLES
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic        i_special_event,
   input  wire logic [9:0]  i_conv_sample,
   output logic             o_wb_ack,
   output logic [31:0]      o_wb_dat,
   output logic             o_irq,
   output logic             o_clr_first_timer,
   output logic             o_clr_third_timer,
   output logic             o_conv_go,
   output logic [2:0]       o_channel
);
   // ****************************************
   // bus access
   // ****************************************
   logic acc;
   logic wr;
   logic rd;

   acet_wb_slave u_wb (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_ce     (i_ce),
      .i_wb_cyc (i_wb_cyc),
      .i_wb_stb (i_wb_stb),
      .o_acc    (acc),
      .o_wb_ack (o_wb_ack)
   );

   function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] off);
      wr_hit = (adr == off);
   endfunction

   // only lane 0 carries register data
   assign wr = acc & i_wb_we & i_wb_sel[0];
   assign rd = acc & ~i_wb_we;

   // ****************************************
   // register state
   // ****************************************
   logic [7:0] flags1_r, flags1_nxt;
   logic [7:0] en1_r, en1_nxt;
   logic [7:0] pri1_r, pri1_nxt;
   logic [7:0] flags2_r, flags2_nxt;
   logic [7:0] en2_r, en2_nxt;
   logic [7:0] pri2_r, pri2_nxt;
   logic [7:0] res_hi_r, res_hi_nxt;
   logic [7:0] res_lo_r, res_lo_nxt;
   logic [7:0] ctl0_r, ctl0_nxt;
   logic [7:0] ctl1_r, ctl1_nxt;
   logic [7:0] cmp_r, cmp_nxt;
   logic [7:0] irq_st_r, irq_st_nxt;
   logic [7:0] irq_mask_r, irq_mask_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic        irq_r, irq_nxt;
   logic        clr1_r, clr1_nxt;
   logic        clr3_r, clr3_nxt;

   logic trig_mode;
   logic evt;
   logic trig;
   logic done;
   logic busy;
   logic [7:0] wd;

   assign wd        = i_wb_dat[7:0];
   assign trig_mode = (cmp_r[3:0] == `ACET_MODE_SPECIAL_EVT);
   assign evt       = i_special_event & trig_mode;
   assign trig      = evt & ctl0_r[`ACET_BIT_CONV_ON];

   acet_conv_seq #(
      .CONV_CYCLES (CONV_CYCLES)
   ) u_seq (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_go    (ctl0_r[`ACET_BIT_GO]),
      .o_busy  (busy),
      .o_done  (done)
   );

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      flags1_nxt   = flags1_r;
      en1_nxt      = en1_r;
      pri1_nxt     = pri1_r;
      flags2_nxt   = flags2_r;
      en2_nxt      = en2_r;
      pri2_nxt     = pri2_r;
      res_hi_nxt   = res_hi_r;
      res_lo_nxt   = res_lo_r;
      ctl0_nxt     = ctl0_r;
      ctl1_nxt     = ctl1_r;
      cmp_nxt      = cmp_r;
      irq_st_nxt   = irq_st_r;
      irq_mask_nxt = irq_mask_r;
      rdat_nxt     = rdat_r;

      // software writes; hardware sets below override them
      if (wr) begin
         // reserved port bit never stored
         if (wr_hit(i_wb_adr, `ACET_OFF_FLAGS_ONE))    flags1_nxt   = wd & `ACET_MASK_PORT_RSVD;
         if (wr_hit(i_wb_adr, `ACET_OFF_ENABLES_ONE))  en1_nxt      = wd & `ACET_MASK_PORT_RSVD;
         if (wr_hit(i_wb_adr, `ACET_OFF_PRIORITY_ONE)) pri1_nxt     = wd & `ACET_MASK_PORT_RSVD;
         if (wr_hit(i_wb_adr, `ACET_OFF_FLAGS_TWO))    flags2_nxt   = wd & `ACET_MASK_FLAGS_TWO;
         if (wr_hit(i_wb_adr, `ACET_OFF_ENABLES_TWO))  en2_nxt      = wd & `ACET_MASK_FLAGS_TWO;
         if (wr_hit(i_wb_adr, `ACET_OFF_PRIORITY_TWO)) pri2_nxt     = wd & `ACET_MASK_FLAGS_TWO;
         if (wr_hit(i_wb_adr, `ACET_OFF_RESULT_HIGH))  res_hi_nxt   = wd;
         if (wr_hit(i_wb_adr, `ACET_OFF_RESULT_LOW))   res_lo_nxt   = wd;
         if (wr_hit(i_wb_adr, `ACET_OFF_CONTROL_ZERO)) ctl0_nxt     = wd & `ACET_MASK_CONTROL_ZERO;
         if (wr_hit(i_wb_adr, `ACET_OFF_CONTROL_ONE))  ctl1_nxt     = wd & `ACET_MASK_CONTROL_ONE;
         if (wr_hit(i_wb_adr, `ACET_OFF_COMPARE_CTL))  cmp_nxt      = wd & `ACET_MASK_COMPARE_CTL;
         if (wr_hit(i_wb_adr, `ACET_OFF_IRQ_MASK))     irq_mask_nxt = wd;
      end

      // go cannot be set while the converter is off
      if (!ctl0_nxt[`ACET_BIT_CONV_ON]) begin
         ctl0_nxt[`ACET_BIT_GO] = 1'b0;
      end

      if (done) begin
         ctl0_nxt[`ACET_BIT_GO] = 1'b0;
         if (ctl1_r[`ACET_BIT_RIGHT_JUST]) begin
            res_hi_nxt = {6'h00, i_conv_sample[9:8]};
            res_lo_nxt = i_conv_sample[7:0];
         end else begin
            res_hi_nxt = i_conv_sample[9:2];
            res_lo_nxt = {i_conv_sample[1:0], 6'h00};
         end
         flags1_nxt[`ACET_BIT_CONV_FLAG] = 1'b1;
      end

      // trigger wins over a completion or a clearing write in the same cycle,
      // but never over software switching the converter off
      if (trig && ctl0_nxt[`ACET_BIT_CONV_ON]) begin
         ctl0_nxt[`ACET_BIT_GO] = 1'b1;
      end
      if (evt) begin
         flags2_nxt[`ACET_BIT_CMP_TWO_FLAG] = 1'b1;
      end

      // read-clear of the status; a set in the same cycle survives
      if (rd && wr_hit(i_wb_adr, `ACET_OFF_IRQ_STATUS)) begin
         irq_st_nxt = 8'h00;
      end
      if (evt) begin
         irq_st_nxt[`ACET_IRQ_SPECIAL_EVT] = 1'b1;
      end
      if (done) begin
         irq_st_nxt[`ACET_IRQ_CONV_DONE] = 1'b1;
      end
      if (evt && !ctl0_r[`ACET_BIT_CONV_ON]) begin
         irq_st_nxt[`ACET_IRQ_IGNORED] = 1'b1;
      end

      if (rd) begin
         case (i_wb_adr)
            `ACET_OFF_FLAGS_ONE:    rdat_nxt = {24'h000000, flags1_r};
            `ACET_OFF_ENABLES_ONE:  rdat_nxt = {24'h000000, en1_r};
            `ACET_OFF_PRIORITY_ONE: rdat_nxt = {24'h000000, pri1_r};
            `ACET_OFF_FLAGS_TWO:    rdat_nxt = {24'h000000, flags2_r};
            `ACET_OFF_ENABLES_TWO:  rdat_nxt = {24'h000000, en2_r};
            `ACET_OFF_PRIORITY_TWO: rdat_nxt = {24'h000000, pri2_r};
            `ACET_OFF_RESULT_HIGH:  rdat_nxt = {24'h000000, res_hi_r};
            `ACET_OFF_RESULT_LOW:   rdat_nxt = {24'h000000, res_lo_r};
            `ACET_OFF_CONTROL_ZERO: rdat_nxt = {24'h000000, ctl0_r};
            `ACET_OFF_CONTROL_ONE:  rdat_nxt = {24'h000000, ctl1_r};
            `ACET_OFF_COMPARE_CTL:  rdat_nxt = {24'h000000, cmp_r};
            `ACET_OFF_IRQ_STATUS:   rdat_nxt = {24'h000000, irq_st_r};
            `ACET_OFF_IRQ_MASK:     rdat_nxt = {24'h000000, irq_mask_r};
            default:                rdat_nxt = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // timer clear and interrupt
   // ****************************************
   always_comb begin
      // timer cleared whether or not the converter is on
      clr1_nxt = evt & ~cmp_r[`ACET_BIT_TIMER_THIRD];
      clr3_nxt = evt & cmp_r[`ACET_BIT_TIMER_THIRD];
      irq_nxt  = |(irq_st_nxt & irq_mask_nxt);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags1_r   <= `ACET_RST_FLAGS_ONE;
         en1_r      <= `ACET_RST_ENABLES_ONE;
         pri1_r     <= `ACET_RST_PRIORITY_ONE;
         flags2_r   <= `ACET_RST_FLAGS_TWO;
         en2_r      <= `ACET_RST_ENABLES_TWO;
         pri2_r     <= `ACET_RST_PRIORITY_TWO;
         res_hi_r   <= `ACET_RST_RESULT;
         res_lo_r   <= `ACET_RST_RESULT;
         ctl0_r     <= `ACET_RST_CONTROL_ZERO;
         ctl1_r     <= `ACET_RST_CONTROL_ONE;
         cmp_r      <= `ACET_RST_COMPARE_CTL;
         irq_st_r   <= `ACET_RST_IRQ;
         irq_mask_r <= `ACET_RST_IRQ;
         rdat_r     <= 32'h00000000;
         irq_r      <= 1'b0;
         clr1_r     <= 1'b0;
         clr3_r     <= 1'b0;
      end else if (i_ce) begin
         flags1_r   <= flags1_nxt;
         en1_r      <= en1_nxt;
         pri1_r     <= pri1_nxt;
         flags2_r   <= flags2_nxt;
         en2_r      <= en2_nxt;
         pri2_r     <= pri2_nxt;
         res_hi_r   <= res_hi_nxt;
         res_lo_r   <= res_lo_nxt;
         ctl0_r     <= ctl0_nxt;
         ctl1_r     <= ctl1_nxt;
         cmp_r      <= cmp_nxt;
         irq_st_r   <= irq_st_nxt;
         irq_mask_r <= irq_mask_nxt;
         rdat_r     <= rdat_nxt;
         irq_r      <= irq_nxt;
         clr1_r     <= clr1_nxt;
         clr3_r     <= clr3_nxt;
      end
   end

   assign o_wb_dat          = rdat_r;
   assign o_irq             = irq_r;
   assign o_clr_first_timer = clr1_r;
   assign o_clr_third_timer = clr3_r;
   assign o_conv_go         = ctl0_r[`ACET_BIT_GO];
   assign o_channel         = ctl0_r[5:3];

   // ****************************************
   // checks
   // ****************************************
   logic ctl0_wr;
   assign ctl0_wr = wr & wr_hit(i_wb_adr, `ACET_OFF_CONTROL_ZERO);

   a_trigger_sets_go: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_special_event && trig_mode && ctl0_r[`ACET_BIT_CONV_ON] && !ctl0_wr)
      |=> o_conv_go ##1 (busy || !o_conv_go)) else $error("trigger did not start a conversion");

   a_wrong_mode_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_special_event && !trig_mode && !o_conv_go && !ctl0_wr)
      |=> !o_conv_go) else $error("conversion started outside mode 1011");

   a_off_ignores_evt: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_special_event && trig_mode && !ctl0_r[`ACET_BIT_CONV_ON])
      |=> (!o_conv_go && (o_clr_first_timer || o_clr_third_timer))) else $error("event with converter off");

   a_timer_cleared: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && i_special_event && trig_mode)
      |=> (o_clr_third_timer == $past(cmp_r[`ACET_BIT_TIMER_THIRD])) && (o_clr_first_timer != o_clr_third_timer))
      else $error("wrong timer cleared on special event");

   a_clear_needs_evt: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_clr_first_timer || o_clr_third_timer) |-> $past(i_special_event && trig_mode))
      else $error("timer cleared without special event");

   a_done_completes: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && done && !i_special_event)
      |=> (!o_conv_go && flags1_r[`ACET_BIT_CONV_FLAG] && irq_st_r[`ACET_IRQ_CONV_DONE]))
      else $error("completion did not clear go and set flag");

   a_go_needs_on: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_conv_go |-> ctl0_r[`ACET_BIT_CONV_ON])
      else $error("conversion running with converter off");

   a_ce_freeze: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !i_ce |=> ($stable(ctl0_r) && $stable(irq_st_r) && $stable(o_wb_ack)))
      else $error("state moved while clock enable low");

   a_status_read_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && rd && (i_wb_adr == `ACET_OFF_IRQ_STATUS) && !evt && !done) |=> (irq_st_r == 8'h00))
      else $error("status not cleared by its read");

   a_evt_sets_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && evt) |=> (flags2_r[`ACET_BIT_CMP_TWO_FLAG] && irq_st_r[`ACET_IRQ_SPECIAL_EVT]))
      else $error("special event did not set its flags");
endmodule
`default_nettype wire

// ===== dv/acet_cmp_model.sv
// compare unit with its timer, source of the special event
`default_nettype none
module acet_cmp_model #(
   parameter int PERIOD = 20
) (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_run,
   input  wire logic       i_clr_first,
   input  wire logic       i_clr_third,
   input  wire logic       i_third_sel,
   output logic            o_event,
   output logic [7:0]      o_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // the timer period stands for the acquisition time before each event
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count <= 8'h00;
         o_event <= 1'b0;
      end else begin
         o_event <= i_run && (o_count == 8'(PERIOD - 2));
         // only the timer serving the compare unit obeys its clear
         if (i_third_sel ? i_clr_third : i_clr_first) begin
            o_count <= 8'h00;
         end else if (i_run) begin
            o_count <= o_count + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/acet_top_tb.sv
// self-checking bench of the compare-event converter trigger
`default_nettype none
`include "acet_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module acet_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_mclk = 1'b0;
   logic        rst_n  = 1'b0;
   logic        cyc    = 1'b0;
   logic        stb    = 1'b0;
   logic        we     = 1'b0;
   logic        run    = 1'b0;
   logic        ce     = 1'b1;
   logic        tsel   = 1'b0;
   logic [7:0]  adr    = 8'h00;
   logic [31:0] wdat   = 32'h0;
   logic [31:0] rdat;
   logic        ack, irq, clr1, clr3, go, evt, go_q;
   logic [2:0]  chan;
   logic [7:0]  q;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n_c1 = 0;
   int          n_c3 = 0;
   int          n_go = 0;
   int          n_evt = 0;
   int          c1, c3, g;
   // cases: on+right, on+left on third timer, off, wrong mode
   logic [7:0]  ctl0 [4] = '{8'h19, 8'h19, 8'h00, 8'h19};
   logic [7:0]  ctl1 [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
   logic [7:0]  cmp  [4] = '{8'h0B, 8'h1B, 8'h1B, 8'h0A};
   logic [7:0]  msk  [4] = '{8'h07, 8'h07, 8'h00, 8'h07};
   logic [7:0]  st   [4] = '{8'h03, 8'h03, 8'h05, 8'h00};
   logic [15:0] res  [2] = '{16'h02A5, 16'hA940};
   int          e1   [4] = '{1, 0, 0, 0};
   int          e3   [4] = '{0, 1, 1, 0};
   int          eg   [4] = '{1, 1, 0, 0};
   logic        eirq [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   always #20 i_mclk = ~i_mclk;

   acet_top #(.CONV_CYCLES(3)) u_dut (
      .i_mclk(i_mclk), .i_rst_n(rst_n), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
      .i_special_event(evt), .i_conv_sample(10'h2A5), .o_wb_ack(ack), .o_wb_dat(rdat),
      .o_irq(irq), .o_clr_first_timer(clr1), .o_clr_third_timer(clr3), .o_conv_go(go),
      .o_channel(chan)
   );
   acet_cmp_model #(.PERIOD(20)) u_cmp (
      .i_mclk(i_mclk), .i_rst_n(rst_n), .i_run(run), .i_clr_first(clr1),
      .i_clr_third(clr3), .i_third_sel(tsel), .o_event(evt), .o_count()
   );

   // ************************************************************
   // pulse counters and timeout
   // ************************************************************
   // one-cycle pulses are counted here so no wait can miss them
   always @(posedge i_mclk) begin
      cycles++;
      n_c1 += int'(clr1 === 1'b1);
      n_c3 += int'(clr3 === 1'b1);
      n_evt += int'(evt === 1'b1);
      n_go += int'(go === 1'b1 && go_q !== 1'b1);
      go_q <= go;
      if (cycles == 5000) begin
         err_total++;
         wrap_up();
      end
   end

   // ************************************************************
   // bus tasks
   // ************************************************************
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      // no cycle count assumed: only the bench timeout ends this wait
      do begin
         @(posedge i_mclk);
      end while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic fire();
      int n;
      int e0;
      n = 0;
      e0 = n_evt;
      run <= 1'b1;
      // a free-running timer may need a full wrap of its counter
      while (n_evt == e0 && n < 300) begin
         @(posedge i_mclk);
         n++;
      end
      run <= 1'b0;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while ((go !== 1'b0 || n < 3) && n < 60);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge i_mclk);
      rst_n <= 1'b1;
      // reset values, with the unmapped tail reading zero
      for (int a = 0; a < 64; a += 4) begin
         wb(1'b0, 8'(a), 8'h00);
         `CHK(q, (8'(a) == `ACET_OFF_PRIORITY_TWO) ? `ACET_RST_PRIORITY_TWO : 8'h00)
      end
      wb(1'b1, `ACET_OFF_CONTROL_ONE, 8'hFF);
      wb(1'b0, `ACET_OFF_CONTROL_ONE, 8'h00);
      `CHK(q, `ACET_MASK_CONTROL_ONE)
      wb(1'b1, `ACET_OFF_ENABLES_ONE, 8'h7F);
      wb(1'b0, `ACET_OFF_ENABLES_ONE, 8'h00);
      `CHK(q, 8'h7F)
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `ACET_OFF_CONTROL_ONE, ctl1[i]);
         wb(1'b1, `ACET_OFF_IRQ_MASK, msk[i]);
         wb(1'b1, `ACET_OFF_COMPARE_CTL, cmp[i]);
         tsel <= cmp[i][4];
         // completion flag cleared so each case must set it anew
         wb(1'b1, `ACET_OFF_FLAGS_ONE, 8'h00);
         // channel chosen before the timer starts the acquisition period
         wb(1'b1, `ACET_OFF_CONTROL_ZERO, ctl0[i]);
         `CHK(chan, ctl0[i][5:3])
         c1 = n_c1;
         c3 = n_c3;
         g = n_go;
         fire();
         `CHK(n_c1 - c1, e1[i])
         `CHK(n_c3 - c3, e3[i])
         `CHK(n_go - g, eg[i])
         `CHK(go, 1'b0)
         `CHK(irq, eirq[i])
         if (eg[i] == 1) begin
            wb(1'b0, `ACET_OFF_RESULT_HIGH, 8'h00);
            `CHK(q, res[i][15:8])
            wb(1'b0, `ACET_OFF_RESULT_LOW, 8'h00);
            `CHK(q, res[i][7:0])
            wb(1'b0, `ACET_OFF_FLAGS_ONE, 8'h00);
            `CHK(q[`ACET_BIT_CONV_FLAG], 1'b1)
         end
         wb(1'b0, `ACET_OFF_IRQ_STATUS, 8'h00);
         `CHK(q, st[i])
         wb(1'b0, `ACET_OFF_IRQ_STATUS, 8'h00);
         `CHK(q, 8'h00)
         `CHK(irq, 1'b0)
      end
      // frozen block lets the event pass unseen and keeps its state
      wb(1'b1, `ACET_OFF_COMPARE_CTL, 8'h0B);
      ce <= 1'b0;
      c1 = n_c1;
      g = n_go;
      fire();
      ce <= 1'b1;
      `CHK(n_c1 - c1, 0)
      `CHK(n_go - g, 0)
      wb(1'b0, `ACET_OFF_IRQ_STATUS, 8'h00);
      `CHK(q, 8'h00)
      wrap_up();
   end
endmodule
`default_nettype wire
